/* File: include/iepr_defines.svh */
`ifndef IEPR_DEFINES_SVH
`define IEPR_DEFINES_SVH

// Register offsets on the register port
`define IEPR_OFS_IE 8'ha8
`define IEPR_OFS_IP 8'hb8
`define IEPR_OFS_CFG 8'he4
`define IEPR_OFS_EIE 8'he6
`define IEPR_OFS_EIP 8'hf6
`define IEPR_OFS_STAT 8'hf0
`define IEPR_OFS_MASK 8'hf1

// Reset values
`define IEPR_RST_IE 8'h00
`define IEPR_RST_IP 8'hc0
`define IEPR_RST_CFG 8'h01
`define IEPR_RST_EIE 8'h00
`define IEPR_RST_EIP 8'hc0
`define IEPR_RST_STAT 8'h00
`define IEPR_RST_MASK 8'h00

// Unused top bits of the priority registers read as ones
`define IEPR_PRI_UNUSED 2'b11
// Unused top bits of the extended enable register read as zeros
`define IEPR_EIE_UNUSED 2'b00
`define IEPR_RD_IDLE 8'h00

// Source count and source indices in fixed service order
`define IEPR_NSRC 12
`define IEPR_SRC_TIMER2 4'h5
`define IEPR_SRC_TWO_WIRE 4'h6
`define IEPR_SRC_WINDOW 4'h7
`define IEPR_SRC_CMP_FALL 4'ha
`define IEPR_SRC_CMP_RISE 4'hb

// Event bit positions in the status register
`define IEPR_EV_TAKEN 0
`define IEPR_EV_PREEMPT 1
`define IEPR_EV_ORPHAN 2

`endif

/* File: include/iepr_pkg.sv */
package iepr_pkg;

	typedef struct packed {
		logic global_irq_enable;
		logic general_flag_in_enable_reg;
		logic timer2_irq_mask;
		logic serial_port_irq_mask;
		logic timer1_irq_mask;
		logic external1_irq_mask;
		logic timer0_irq_mask;
		logic external0_irq_mask;
	} iepr_ie_s;

	typedef struct packed {
		logic [1:0] unused;
		logic timer2_priority;
		logic serial_port_priority;
		logic timer1_priority;
		logic external1_priority;
		logic timer0_priority;
		logic external0_priority;
	} iepr_ip_s;

	typedef struct packed {
		logic [1:0] unused;
		logic comparator_rise_mask;
		logic comparator_fall_mask;
		logic counter_array_mask;
		logic conversion_done_mask;
		logic window_compare_mask;
		logic two_wire_bus_mask;
	} iepr_eie_s;

	typedef struct packed {
		logic [1:0] unused;
		logic comparator_rise_priority;
		logic comparator_fall_priority;
		logic counter_array_priority;
		logic conversion_done_priority;
		logic window_compare_priority;
		logic two_wire_bus_priority;
	} iepr_eip_s;

	typedef struct packed {
		logic external1_polarity;
		logic [2:0] external1_pin_select;
		logic external0_polarity;
		logic [2:0] external0_pin_select;
	} iepr_cfg_s;

	typedef struct packed {
		logic comparator_rise;
		logic comparator_fall;
		logic counter_array;
		logic conversion_done;
		logic window_compare;
		logic two_wire_bus;
		logic timer2_low_overflow_flag;
		logic timer2_high_overflow_flag;
		logic serial_port;
		logic timer1;
		logic timer0;
	} iepr_pend_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} iepr_bus_s;

	typedef struct packed {
		logic valid;
		logic high;
		logic [3:0] id;
	} iepr_vec_s;

	typedef enum logic [1:0] {
		SVC_IDLE,
		SVC_LOW,
		SVC_HIGH,
		SVC_LOW_HIGH
	} iepr_svc_e;

endpackage

/* File: hdl/iepr_pin_sel.sv */
`timescale 1ns/1ps
// Picks one port 0 pin and turns it into an active-high request
module iepr_pin_sel (
	input wire logic [7:0] port_pins_i,
	input wire logic [2:0] pin_select_i,
	input wire logic polarity_i,
	output logic active_o
);
	logic pin;

	// RULE_10: pin routing
	// RULE_11: read only, never drives
	assign pin = port_pins_i[pin_select_i];
	// RULE_12: polarity, 0 is active low
	assign active_o = polarity_i ? pin : ~pin;
endmodule // iepr_pin_sel

/* File: hdl/iepr_top.sv */
// Functional notes
// RULE_01: Global enable off blocks every source
// RULE_02: Enable bit 6 is inert software flag
// RULE_03: Timer 2 mask gates both overflow flags
// RULE_04: Priority bits per source, 1 is high
// RULE_05: Extended bits 5,4 mask comparator edges
// RULE_06: Extended bit 1 masks window compare
// RULE_07: Extended bit 0 masks two-wire bus
// RULE_08: Extended priority bit 1: window compare
// RULE_09: Extended priority bit 0: two-wire bus
// RULE_10: Three-bit field routes port pin n
// RULE_11: External inputs sample pins without disturbing
// RULE_12: Polarity bit: 0 low, 1 high active
// RULE_13: High preempts low; high never preempted
// RULE_14: Equal level resolved by fixed order
// RULE_15: Other extended priority bits, 1 is high
`timescale 1ns/1ps
`include "iepr_defines.svh"
module iepr_top (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire iepr_pkg::iepr_bus_s bus_i,
	output logic [7:0] rdata_o,
	input wire iepr_pkg::iepr_pend_s pend_i,
	input wire logic [7:0] port_pins_i,
	input wire logic vec_ack_i,
	input wire logic reti_i,
	output iepr_pkg::iepr_vec_s vector_o,
	output logic [1:0] ext_active_o,
	output logic irq_o
);
	iepr_pkg::iepr_ie_s ie_q;
	iepr_pkg::iepr_ip_s ip_q;
	iepr_pkg::iepr_eie_s eie_q;
	iepr_pkg::iepr_eip_s eip_q;
	iepr_pkg::iepr_cfg_s cfg_q;
	iepr_pkg::iepr_svc_e svc;
	iepr_pkg::iepr_vec_s next_vec;
	logic [7:0] stat_q;
	logic [7:0] mask_q;
	logic [7:0] ev;
	logic [7:0] next_stat;
	logic [7:0] rd_val;
	logic [1:0] ext_act;
	logic [`IEPR_NSRC-1:0] src;
	logic [`IEPR_NSRC-1:0] en;
	logic [`IEPR_NSRC-1:0] pri;
	logic [`IEPR_NSRC-1:0] req;
	logic [`IEPR_NSRC-1:0] hi_req;
	logic [`IEPR_NSRC-1:0] cand;
	logic hi_any;
	logic ok;
	logic take;
	logic wr_ie;
	logic wr_ip;
	logic wr_cfg;
	logic wr_eie;
	logic wr_eip;
	logic wr_mask;
	logic rd_stat;

	// Register port decode
	assign wr_ie = bus_i.wr && (bus_i.addr == `IEPR_OFS_IE);
	assign wr_ip = bus_i.wr && (bus_i.addr == `IEPR_OFS_IP);
	assign wr_cfg = bus_i.wr && (bus_i.addr == `IEPR_OFS_CFG);
	assign wr_eie = bus_i.wr && (bus_i.addr == `IEPR_OFS_EIE);
	assign wr_eip = bus_i.wr && (bus_i.addr == `IEPR_OFS_EIP);
	assign wr_mask = bus_i.wr && (bus_i.addr == `IEPR_OFS_MASK);
	assign rd_stat = bus_i.rd && (bus_i.addr == `IEPR_OFS_STAT);

	// Enable register, bit 6 is only stored
	// RULE_02: software flag stored
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ie_q <= `IEPR_RST_IE;
		end else if (wr_ie) begin
			ie_q <= bus_i.wdata;
		end
	end

	// Priority register, unused bits stay set
	// RULE_04: per-source priority bits
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ip_q <= `IEPR_RST_IP;
		end else if (wr_ip) begin
			ip_q <= {`IEPR_PRI_UNUSED, bus_i.wdata[5:0]};
		end
	end

	// Pin routing and polarity configuration
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cfg_q <= `IEPR_RST_CFG;
		end else if (wr_cfg) begin
			cfg_q <= bus_i.wdata;
		end
	end

	// Extended enable, unused bits read zero
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			eie_q <= `IEPR_RST_EIE;
		end else if (wr_eie) begin
			eie_q <= {`IEPR_EIE_UNUSED, bus_i.wdata[5:0]};
		end
	end

	// Extended priority, unused bits stay set
	// RULE_15: same scheme for all bits
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			eip_q <= `IEPR_RST_EIP;
		end else if (wr_eip) begin
			eip_q <= {`IEPR_PRI_UNUSED, bus_i.wdata[5:0]};
		end
	end

	// Event mask register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			mask_q <= `IEPR_RST_MASK;
		end else if (wr_mask) begin
			mask_q <= bus_i.wdata;
		end
	end

	// External request pins
	iepr_pin_sel u_ext0 (
		.port_pins_i(port_pins_i),
		.pin_select_i(cfg_q.external0_pin_select),
		.polarity_i(cfg_q.external0_polarity),
		.active_o(ext_act[0])
	);

	iepr_pin_sel u_ext1 (
		.port_pins_i(port_pins_i),
		.pin_select_i(cfg_q.external1_pin_select),
		.polarity_i(cfg_q.external1_polarity),
		.active_o(ext_act[1])
	);

	// Sources in fixed service order, index 0 first
	// RULE_03: both timer 2 flags share one source
	assign src = {pend_i.comparator_rise, pend_i.comparator_fall,
		pend_i.counter_array, pend_i.conversion_done,
		pend_i.window_compare, pend_i.two_wire_bus,
		pend_i.timer2_low_overflow_flag | pend_i.timer2_high_overflow_flag,
		pend_i.serial_port, pend_i.timer1, ext_act[1],
		pend_i.timer0, ext_act[0]};

	// Per-source masks
	// RULE_05: comparator edge masks
	// RULE_06: window compare mask
	// RULE_07: two-wire bus mask
	assign en = {eie_q.comparator_rise_mask, eie_q.comparator_fall_mask,
		eie_q.counter_array_mask, eie_q.conversion_done_mask,
		eie_q.window_compare_mask, eie_q.two_wire_bus_mask,
		ie_q.timer2_irq_mask, ie_q.serial_port_irq_mask,
		ie_q.timer1_irq_mask, ie_q.external1_irq_mask,
		ie_q.timer0_irq_mask, ie_q.external0_irq_mask};

	// Per-source priority levels
	// RULE_08: window compare level
	// RULE_09: two-wire bus level
	assign pri = {eip_q.comparator_rise_priority,
		eip_q.comparator_fall_priority, eip_q.counter_array_priority,
		eip_q.conversion_done_priority, eip_q.window_compare_priority,
		eip_q.two_wire_bus_priority, ip_q.timer2_priority,
		ip_q.serial_port_priority, ip_q.timer1_priority,
		ip_q.external1_priority, ip_q.timer0_priority,
		ip_q.external0_priority};

	// Gated requests
	// RULE_01: global enable over all masks
	assign req = ie_q.global_irq_enable ? (src & en) : '0;
	assign hi_req = req & pri;
	assign hi_any = |hi_req;
	assign cand = hi_any ? hi_req : req;
	assign take = vec_ack_i && vector_o.valid;

	// Arbitration of the next vector
	// RULE_14: lowest index wins within a level
	always_comb begin
		next_vec = '0;
		next_vec.high = hi_any;
		for (int i = `IEPR_NSRC - 1; i >= 0; i--) begin
			if (cand[i]) begin
				next_vec.id = 4'(i);
			end
		end
		// RULE_13: preemption only from low service
		case (svc)
			iepr_pkg::SVC_IDLE: ok = |cand;
			iepr_pkg::SVC_LOW: ok = hi_any;
			default: ok = 1'b0;
		endcase
		next_vec.valid = ok && !vec_ack_i && !reti_i;
	end

	// Offered vector, withdrawn for a cycle after ack or return
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			vector_o <= '0;
		end else begin
			vector_o <= next_vec;
		end
	end

	// Service nesting state
	// RULE_13: nesting of low and high service
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			svc <= iepr_pkg::SVC_IDLE;
		end else begin
			case (svc)
				iepr_pkg::SVC_IDLE: begin
					if (take) begin
						svc <= vector_o.high ? iepr_pkg::SVC_HIGH
							: iepr_pkg::SVC_LOW;
					end
				end
				iepr_pkg::SVC_LOW: begin
					if (take) begin
						svc <= iepr_pkg::SVC_LOW_HIGH;
					end else if (reti_i) begin
						svc <= iepr_pkg::SVC_IDLE;
					end
				end
				iepr_pkg::SVC_HIGH: begin
					if (reti_i) begin
						svc <= iepr_pkg::SVC_IDLE;
					end
				end
				iepr_pkg::SVC_LOW_HIGH: begin
					if (reti_i) begin
						svc <= iepr_pkg::SVC_LOW;
					end
				end
				default: svc <= iepr_pkg::SVC_IDLE;
			endcase
		end
	end

	// Block events: taken, preempted, stray return
	always_comb begin
		ev = '0;
		ev[`IEPR_EV_TAKEN] = take;
		ev[`IEPR_EV_PREEMPT] = take && (svc == iepr_pkg::SVC_LOW);
		ev[`IEPR_EV_ORPHAN] = reti_i && !take
			&& (svc == iepr_pkg::SVC_IDLE);
	end

	// Sticky status, read clears, a new event wins
	assign next_stat = (rd_stat ? '0 : stat_q) | ev;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			stat_q <= `IEPR_RST_STAT;
			irq_o <= 1'b0;
		end else begin
			stat_q <= next_stat;
			irq_o <= |(next_stat & mask_q);
		end
	end

	// Resolved external levels
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ext_active_o <= '0;
		end else begin
			ext_active_o <= ext_act;
		end
	end

	// Read multiplexer
	always_comb begin
		case (bus_i.addr)
			`IEPR_OFS_IE: rd_val = ie_q;
			`IEPR_OFS_IP: rd_val = ip_q;
			`IEPR_OFS_CFG: rd_val = cfg_q;
			`IEPR_OFS_EIE: rd_val = eie_q;
			`IEPR_OFS_EIP: rd_val = eip_q;
			`IEPR_OFS_STAT: rd_val = stat_q;
			`IEPR_OFS_MASK: rd_val = mask_q;
			default: rd_val = `IEPR_RD_IDLE;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_o <= `IEPR_RD_IDLE;
		end else begin
			rdata_o <= bus_i.rd ? rd_val : `IEPR_RD_IDLE;
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_low_taken;
		svc == iepr_pkg::SVC_LOW && take;
	endsequence

	sequence s_nested_back;
		(svc == iepr_pkg::SVC_LOW_HIGH && !vector_o.valid)
			##1 (svc == iepr_pkg::SVC_LOW_HIGH || svc == iepr_pkg::SVC_LOW);
	endsequence

	chk_global_gate: assert property ( // RULE_01
		!ie_q.global_irq_enable |=> !vector_o.valid)
		else $error("vector offered with global enable off");

	chk_flag_store: assert property ( // RULE_02
		wr_ie |=> ie_q.general_flag_in_enable_reg == $past(bus_i.wdata[6])
			&& vector_o == $past(next_vec))
		else $error("software flag not stored");

	chk_timer2_gate: assert property ( // RULE_03
		!ie_q.timer2_irq_mask |=>
			!(vector_o.valid && vector_o.id == `IEPR_SRC_TIMER2))
		else $error("timer 2 request passed while masked");

	chk_high_first: assert property ( // RULE_04
		vector_o.valid && !vector_o.high |-> !$past(hi_any))
		else $error("low vector chosen over a high request");

	chk_cmp_rise_gate: assert property ( // RULE_05
		!eie_q.comparator_rise_mask |=>
			!(vector_o.valid && vector_o.id == `IEPR_SRC_CMP_RISE))
		else $error("comparator rise passed while masked");

	chk_window_gate: assert property ( // RULE_06
		!eie_q.window_compare_mask |=>
			!(vector_o.valid && vector_o.id == `IEPR_SRC_WINDOW))
		else $error("window compare passed while masked");

	chk_two_wire_gate: assert property ( // RULE_07
		!eie_q.two_wire_bus_mask |=>
			!(vector_o.valid && vector_o.id == `IEPR_SRC_TWO_WIRE))
		else $error("two-wire bus passed while masked");

	chk_ext_route: assert property ( // RULE_10
		ext_active_o[0] == ($past(port_pins_i[cfg_q.external0_pin_select])
			== $past(cfg_q.external0_polarity)) || $past(wr_cfg))
		else $error("external 0 level does not follow its pin");

	chk_high_hold: assert property ( // RULE_13
		svc == iepr_pkg::SVC_HIGH |=> !vector_o.valid)
		else $error("high service was preempted");

	chk_nest_return: assert property ( // RULE_13
		s_low_taken |=> s_nested_back)
		else $error("preemption did not nest");

endmodule // iepr_top

/* File: verif/iepr_core_model.sv */
`timescale 1ns/1ps
// Behavioural core: takes one offered vector per request, returns on demand
module iepr_core_model (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire iepr_pkg::iepr_vec_s vector_i,
	input wire logic take_i,
	input wire logic give_back_i,
	input wire logic [3:0] slow_i,
	output logic vec_ack_o,
	output logic reti_o,
	output iepr_pkg::iepr_vec_s taken_o
);
	logic armed;
	logic [3:0] waited;

	// Acknowledge only while the vector is valid, after slow_i cycles
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			armed <= 1'b0;
			waited <= 4'h0;
			vec_ack_o <= 1'b0;
			taken_o <= '0;
		end else begin
			vec_ack_o <= 1'b0;
			if (take_i) begin
				armed <= 1'b1;
			end else if (armed && vector_i.valid && !vec_ack_o) begin
				if (waited >= slow_i) begin
					vec_ack_o <= 1'b1;
					taken_o <= vector_i;
					armed <= 1'b0;
					waited <= 4'h0;
				end else begin
					waited <= waited + 4'h1;
				end
			end
		end
	end

	// Return pulse one cycle after the bench asks, never in the cycle right after an ack
	always_ff @(posedge clk_i) begin
		reti_o <= resetn_i && give_back_i && !vec_ack_o;
	end
endmodule // iepr_core_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "iepr_defines.svh"
module tb;
	logic clk_i;
	logic resetn_i;
	iepr_pkg::iepr_bus_s bus;
	iepr_pkg::iepr_pend_s pend;
	iepr_pkg::iepr_vec_s vector;
	iepr_pkg::iepr_vec_s taken;
	logic [7:0] rdata;
	logic [7:0] pins;
	logic [1:0] ext_active;
	logic vec_ack;
	logic reti;
	logic irq;
	logic take;
	logic give_back;
	logic [3:0] slow;
	int failures;
	int samples_checked;

	iepr_top i_iepr_top (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus),
		.rdata_o(rdata), .pend_i(pend), .port_pins_i(pins),
		.vec_ack_i(vec_ack), .reti_i(reti), .vector_o(vector),
		.ext_active_o(ext_active), .irq_o(irq));

	iepr_core_model i_iepr_core_model (.clk_i(clk_i), .resetn_i(resetn_i),
		.vector_i(vector), .take_i(take), .give_back_i(give_back),
		.slow_i(slow), .vec_ack_o(vec_ack), .reti_o(reti),
		.taken_o(taken));

	// Free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic print_verdict;
		if (failures == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Register port cycles, entered and left at a rising edge
	// A write lets one idle edge pass so strobes never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk_i);
		bus.wr <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_i);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
		@(posedge clk_i);
	endtask

	task automatic vec_is(input logic v, input logic h, input logic [3:0] n);
		#1;
		if (v) chk({2'b00, vector}, {2'b00, 1'b1, h, n});
		else chk({7'h00, vector.valid}, 8'h00);
		@(posedge clk_i);
	endtask

	task automatic irq_is(input logic e);
		#1;
		chk({7'h00, irq}, {7'h00, e});
		@(posedge clk_i);
	endtask

	task automatic ask(input logic [3:0] s);
		slow <= s;
		take <= 1'b1;
		@(posedge clk_i);
		take <= 1'b0;
	endtask

	task automatic give;
		give_back <= 1'b1;
		@(posedge clk_i);
		give_back <= 1'b0;
	endtask

	// One source alone: masked, unmasked, then raised to high level
	task automatic src(input int b);
		int n;
		n = (b < 2) ? 2 * b + 1 : (b < 5) ? ((b == 2) ? 4 : 5) : b + 1;
		wr(`IEPR_OFS_IE, 8'h80);
		wr(`IEPR_OFS_EIE, 8'h00);
		pend <= iepr_pkg::iepr_pend_s'(11'(1 << b));
		cyc(3);
		vec_is(1'b0, 1'b0, 4'h0);
		if (n < 6) wr(`IEPR_OFS_IE, 8'(8'h80 | (1 << n)));
		else wr(`IEPR_OFS_EIE, 8'(1 << (n - 6)));
		cyc(2);
		vec_is(1'b1, 1'b0, 4'(n));
		if (n < 6) wr(`IEPR_OFS_IP, 8'(1 << n));
		else wr(`IEPR_OFS_EIP, 8'(1 << (n - 6)));
		cyc(2);
		vec_is(1'b1, 1'b1, 4'(n));
		wr(`IEPR_OFS_IP, 8'h00);
		wr(`IEPR_OFS_EIP, 8'h00);
		pend <= '0;
	endtask

	// Hang guard, well beyond the expected run length
	initial begin
		#(25 * 20000);
		failures++;
		print_verdict();
	end

	// Main sequence
	initial begin
		resetn_i = 1'b0;
		bus = '0;
		pend = '0;
		pins = 8'hff;
		take = 1'b0;
		give_back = 1'b0;
		slow = 4'h0;
		failures = 0;
		samples_checked = 0;
		cyc(5);
		resetn_i <= 1'b1;
		// Reset values and access kinds
		rd(`IEPR_OFS_IE, 8'h00);
		rd(`IEPR_OFS_IP, 8'hc0);
		rd(`IEPR_OFS_CFG, 8'h01);
		rd(`IEPR_OFS_EIE, 8'h00);
		rd(`IEPR_OFS_EIP, 8'hc0);
		wr(`IEPR_OFS_IE, 8'h7f);
		rd(`IEPR_OFS_IE, 8'h7f);
		wr(`IEPR_OFS_IP, 8'h3f);
		rd(`IEPR_OFS_IP, 8'hff);
		wr(`IEPR_OFS_EIE, 8'hff);
		rd(`IEPR_OFS_EIE, 8'h3f);
		wr(`IEPR_OFS_EIP, 8'h00);
		rd(`IEPR_OFS_EIP, 8'hc0);
		wr(`IEPR_OFS_CFG, 8'ha5);
		rd(`IEPR_OFS_CFG, 8'ha5);
		#1;
		chk(rdata, `IEPR_RD_IDLE);
		cyc(1);
		wr(8'h10, 8'h55);
		rd(8'h10, 8'h00);
		wr(`IEPR_OFS_IP, 8'h00);
		wr(`IEPR_OFS_CFG, 8'h00);
		for (int b = 0; b < 11; b++) src(b);
		// External inputs: every pin and both polarities
		for (int e = 0; e < 2; e++) begin
			wr(`IEPR_OFS_IE, 8'(8'h80 | (1 << (2 * e))));
			for (int n = 0; n < 8; n++) begin
				for (int p = 0; p < 2; p++) begin
					wr(`IEPR_OFS_CFG, 8'(((p << 3) | n) << (4 * e)));
					pins <= p ? 8'(1 << n) : 8'(~(1 << n));
					cyc(2);
					#1;
					chk({7'h00, ext_active[e]}, 8'h01);
					vec_is(1'b1, 1'b0, 4'(2 * e));
					pins <= ~pins;
					cyc(2);
					#1;
					chk({7'h00, ext_active[e]}, 8'h00);
					vec_is(1'b0, 1'b0, 4'h0);
				end
			end
		end
		pins <= 8'hff;
		wr(`IEPR_OFS_CFG, 8'h00);
		// Global gate, fixed order and level arbitration
		pend <= '1;
		wr(`IEPR_OFS_IE, 8'h7f);
		wr(`IEPR_OFS_EIE, 8'h3f);
		cyc(3);
		vec_is(1'b0, 1'b0, 4'h0);
		wr(`IEPR_OFS_IE, 8'h40);
		cyc(3);
		vec_is(1'b0, 1'b0, 4'h0);
		wr(`IEPR_OFS_IE, 8'hff);
		cyc(2);
		vec_is(1'b1, 1'b0, 4'h1);
		wr(`IEPR_OFS_EIP, 8'h20);
		cyc(2);
		vec_is(1'b1, 1'b1, 4'hb);
		// Nesting: low taken, high preempts, then nothing more
		wr(`IEPR_OFS_EIP, 8'h00);
		wr(`IEPR_OFS_MASK, 8'h01);
		ask(4'h3);
		cyc(8);
		#1;
		chk({2'b00, taken}, 8'h21);
		irq_is(1'b1);
		vec_is(1'b0, 1'b0, 4'h0);
		wr(`IEPR_OFS_EIP, 8'h20);
		cyc(2);
		vec_is(1'b1, 1'b1, 4'hb);
		ask(4'h0);
		cyc(6);
		#1;
		chk({2'b00, taken}, 8'h3b);
		wr(`IEPR_OFS_IP, 8'h02);
		cyc(3);
		vec_is(1'b0, 1'b0, 4'h0);
		rd(`IEPR_OFS_STAT, 8'h03);
		irq_is(1'b0);
		give();
		cyc(3);
		vec_is(1'b1, 1'b1, 4'h1);
		give();
		cyc(3);
		give();
		cyc(3);
		irq_is(1'b0);
		rd(`IEPR_OFS_STAT, 8'h04);
		print_verdict();
	end
endmodule // tb
